// *** include/esil_defs.svh ***
// Functional notes
// [R1] Read-only registers ignore writes; writable registers read back
// [R2] Host writes zero to must-be-zero bits
// [R3] Defer event updates while bus access runs
// [R4] Identity bits 3..1 factory-set; host ignores them
// [R5] Tap flag changes only when detection enabled
// [R6] Reading event status clears and re-arms flags
// [R7] Tap flags bits 0..5, sample flag bit 7
// [R8] Sample flag always set on new sample
// [R9] Polling host reads at sample rate or faster
// [R10] State field: 00 idle, 01 active
// [R11] Watchdog timeout sets bit 4, idles slave
// [R12] Reading device status clears timeout flag
// [R13] Bit 7 high while factory memory busy
// [R14] Enables gate only the pin, not flags
// [R15] Irq enable bits 0..5 taps, reset zero
// [R16] Bit 7 enable raises pin per sample
// [R17] Watchdog declares stall after about 200 ms
// [R18] Pin active low unless polarity bit set
// [R19] Pin held while enabled flag latched
`ifndef ESIL_DEFS_SVH
`define ESIL_DEFS_SVH
`define ESIL_ADDR_EVENT_STATUS    8'h03
`define ESIL_ADDR_DEVICE_STATUS   8'h04
`define ESIL_ADDR_IRQ_ENABLE      8'h06
`define ESIL_ADDR_MODE            8'h07
`define ESIL_ADDR_TAP_CONTROL     8'h09
`define ESIL_ADDR_Y_OFFSET_HIGH   8'h24
`define ESIL_ADDR_Z_OFFSET_LOW    8'h25
`define ESIL_ADDR_Z_OFFSET_HIGH   8'h26
`define ESIL_ADDR_X_GAIN_LOW      8'h27
`define ESIL_ADDR_Y_GAIN_LOW      8'h28
`define ESIL_ADDR_Z_GAIN_LOW      8'h29
`define ESIL_ADDR_PRODUCT_ID      8'h3b
`define ESIL_BIT_SAMPLE_READY     7
`define ESIL_BIT_TIMEOUT          4
`define ESIL_BIT_OTP_BUSY         7
`define ESIL_BIT_POLARITY_HIGH    7
`define ESIL_BIT_WDT_POS          5
`define ESIL_BIT_WDT_NEG          4
`define ESIL_BIT_MODE_MBZ         2
`define ESIL_TAP_MASK             8'h3f
`define ESIL_EVENT_MASK           8'hbf
`define ESIL_IRQ_EN_MASK          8'hbf
`define ESIL_MODE_MASK            8'hf3
`define ESIL_ID_FIXED_MASK        8'hf1
`define ESIL_RESET_BYTE           8'h00
`define ESIL_OPSTATE_IDLE         2'h0
`define ESIL_OPSTATE_ACTIVE       2'h1
`define ESIL_WDT_TIMEOUT_MS       200
`define ESIL_CLK_MHZ              200
`define ESIL_WDT_CYCLES           (`ESIL_WDT_TIMEOUT_MS * 1000 * `ESIL_CLK_MHZ)
// Host register window on APB, byte offsets
`define ESIL_APB_CMD              12'h000
`define ESIL_APB_WDATA            12'h004
`define ESIL_APB_RDATA            12'h008
`define ESIL_APB_STATUS           12'h00c
`define ESIL_APB_IRQ_STATUS       12'h010
`define ESIL_APB_IRQ_MASK         12'h014
`define ESIL_CMD_WRITE_BIT        8
`define ESIL_CMD_GO_BIT           9
`endif

// *** include/esil_pkg.sv ***
package esil_pkg;
    typedef logic [7:0] esil_byte_t;
    typedef enum logic [1:0] {
        ESIL_BUS_IDLE,
        ESIL_BUS_ACCESS,
        ESIL_BUS_DONE
    } esil_bus_e;
    typedef enum logic [1:0] {
        ESIL_HOST_IDLE,
        ESIL_HOST_REQ,
        ESIL_HOST_WAIT
    } esil_host_e;
endpackage : esil_pkg

// *** include/esil_link_if.sv ***
`timescale 1ns/1ps
// Register access link between host controller and sensor logic
interface esil_link_if;
    logic       req;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;
    logic       irq_pin_out;
    logic       irq_pin_oe;
    modport device (input req, input write, input addr, input wdata,
                    output rdata, output ack, output irq_pin_out, output irq_pin_oe);
    modport host (output req, output write, output addr, output wdata,
                  input rdata, input ack, input irq_pin_out, input irq_pin_oe);
endinterface : esil_link_if

// *** hdl/esil_device.sv ***
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "esil_defs.svh"
module esil_device #(
    parameter int unsigned WDT_CYCLES = `ESIL_WDT_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    esil_link_if.device      link,
    input  wire logic [5:0]  tap_event,
    input  wire logic        sample_event,
    input  wire logic        active_state,
    input  wire logic        otp_active,
    input  wire logic        bus_stall,
    input  wire logic [7:0]  factory_id,
    output logic             bus_reset,
    output logic [7:0]       tap_control,
    output logic [7:0]       mode
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        esil_pkg::esil_bus_e bus;
        logic [7:0]          rdata;
        logic                ack;
        logic [7:0]          event_status;
        logic                timeout_flag;
        logic [7:0]          irq_enable;
        logic [7:0]          mode;
        logic [7:0]          tap_control;
        logic [5:0]          tap_hold;
        logic                sample_hold;
        logic [5:0][7:0]     cal;
        logic [7:0]          id;
        logic                id_loaded;
        logic [31:0]         wdt_count;
        logic                bus_reset;
        logic                pin_out;
        logic                pin_oe;
        logic [1:0]          otp_sync;
        logic [1:0]          state_sync;
    } esil_dev_s;

    esil_dev_s r;
    esil_dev_s next_r;
    logic      busy;
    logic      rd_go;
    logic      wr_go;
    logic      irq_any;
    logic [7:0] dev_status;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_r  = r;
        busy    = (r.bus != esil_pkg::ESIL_BUS_IDLE) || link.req;
        rd_go   = (r.bus == esil_pkg::ESIL_BUS_IDLE) && link.req && !link.write;
        wr_go   = (r.bus == esil_pkg::ESIL_BUS_IDLE) && link.req && link.write;
        next_r.otp_sync   = {r.otp_sync[0], otp_active};
        next_r.state_sync = {r.state_sync[0], active_state};
        dev_status = `ESIL_RESET_BYTE;
        dev_status[`ESIL_BIT_OTP_BUSY] = r.otp_sync[1];                   // R13
        dev_status[`ESIL_BIT_TIMEOUT]  = r.timeout_flag;
        dev_status[1:0] = r.state_sync[1] ? `ESIL_OPSTATE_ACTIVE : `ESIL_OPSTATE_IDLE; // R10
        // Strap capture of identity after reset release
        if (!r.id_loaded) begin
            next_r.id        = factory_id;                                  // R4
            next_r.id_loaded = 1'b1;
        end
        // Events are held aside while an access runs
        next_r.tap_hold    = r.tap_hold | (tap_event & r.tap_control[5:0]); // R5
        next_r.sample_hold = r.sample_hold | sample_event;                    // R8
        if (!busy) begin                                                      // R3
            next_r.event_status[5:0] = r.event_status[5:0] | next_r.tap_hold; // R7
            next_r.event_status[`ESIL_BIT_SAMPLE_READY] =
                r.event_status[`ESIL_BIT_SAMPLE_READY] | next_r.sample_hold;
            next_r.tap_hold    = 6'h00;
            next_r.sample_hold = 1'b0;
        end
        // Bus access
        next_r.ack = 1'b0;
        case (r.bus)
            esil_pkg::ESIL_BUS_IDLE: begin
                if (rd_go) begin
                    case (link.addr)
                        `ESIL_ADDR_EVENT_STATUS: begin
                            next_r.rdata        = r.event_status;
                            next_r.event_status = `ESIL_RESET_BYTE;          // R6
                        end
                        `ESIL_ADDR_DEVICE_STATUS: begin
                            next_r.rdata        = dev_status;
                            next_r.timeout_flag = 1'b0;                       // R12
                        end
                        `ESIL_ADDR_IRQ_ENABLE:   next_r.rdata = r.irq_enable;  // R1
                        `ESIL_ADDR_MODE:         next_r.rdata = r.mode;
                        `ESIL_ADDR_TAP_CONTROL:  next_r.rdata = r.tap_control;
                        `ESIL_ADDR_PRODUCT_ID:   next_r.rdata = r.id;
                        default: begin
                            if (link.addr >= `ESIL_ADDR_Y_OFFSET_HIGH && link.addr <= `ESIL_ADDR_Z_GAIN_LOW)
                                next_r.rdata = r.cal[3'(link.addr - `ESIL_ADDR_Y_OFFSET_HIGH)];
                            else
                                next_r.rdata = `ESIL_RESET_BYTE;
                        end
                    endcase
                    next_r.bus = esil_pkg::ESIL_BUS_ACCESS;
                end else if (wr_go) begin
                    case (link.addr)                                          // R1
                        `ESIL_ADDR_IRQ_ENABLE:  next_r.irq_enable  = link.wdata & `ESIL_IRQ_EN_MASK; // R15
                        `ESIL_ADDR_MODE:        next_r.mode        = link.wdata & `ESIL_MODE_MASK;
                        `ESIL_ADDR_TAP_CONTROL: next_r.tap_control = link.wdata;
                        default: begin
                            if (link.addr >= `ESIL_ADDR_Y_OFFSET_HIGH && link.addr <= `ESIL_ADDR_Z_GAIN_LOW)
                                next_r.cal[3'(link.addr - `ESIL_ADDR_Y_OFFSET_HIGH)] = link.wdata;
                        end
                    endcase
                    next_r.bus = esil_pkg::ESIL_BUS_ACCESS;
                end
            end
            esil_pkg::ESIL_BUS_ACCESS: begin
                next_r.ack = 1'b1;
                next_r.bus = esil_pkg::ESIL_BUS_DONE;
            end
            esil_pkg::ESIL_BUS_DONE: begin
                if (!link.req)
                    next_r.bus = esil_pkg::ESIL_BUS_IDLE;
            end
            default: next_r.bus = esil_pkg::ESIL_BUS_IDLE;
        endcase
        // Bus watchdog on a stalled read
        next_r.bus_reset = 1'b0;
        if (bus_stall && (r.mode[`ESIL_BIT_WDT_POS] || r.mode[`ESIL_BIT_WDT_NEG])) begin
            if (r.wdt_count >= WDT_CYCLES - 1) begin                         // R17
                next_r.wdt_count    = 32'h0;
                next_r.timeout_flag = 1'b1;                                   // R11
                next_r.bus_reset    = 1'b1;
                next_r.bus          = esil_pkg::ESIL_BUS_IDLE;
            end else begin
                next_r.wdt_count = r.wdt_count + 32'h1;
            end
        end else begin
            next_r.wdt_count = 32'h0;
        end
        // Interrupt pin from latched flags gated by enables
        irq_any = |(r.event_status & r.irq_enable & `ESIL_EVENT_MASK);       // R14 R16 R19
        next_r.pin_out = irq_any ^ !r.mode[`ESIL_BIT_POLARITY_HIGH];        // R18
        next_r.pin_oe  = 1'b1;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r        <= '0;
            r.pin_out <= 1'b1;
            r.pin_oe  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.rdata       = r.rdata;
    assign link.ack         = r.ack;
    assign link.irq_pin_out = r.pin_out;
    assign link.irq_pin_oe  = r.pin_oe;
    assign bus_reset        = r.bus_reset;
    assign tap_control      = r.tap_control;
    assign mode             = r.mode;
endmodule : esil_device

// *** hdl/esil_host.sv ***
`timescale 1ns/1ps
`include "esil_defs.svh"
module esil_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    esil_link_if.host        link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        esil_pkg::esil_host_e st;
        logic [7:0]  addr;
        logic        write;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        req;
        logic [1:0]  pin_sync;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic        pin_seen;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
    } esil_host_s;

    esil_host_s r;
    esil_host_s next_r;
    logic       access;
    logic       pin_active;
    logic       done_ev;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_r   = r;
        access   = psel && penable && !r.pready;
        next_r.pin_sync = {r.pin_sync[0], link.irq_pin_oe ? link.irq_pin_out : 1'b1};
        pin_active = !r.pin_sync[1];                       // Pin is read active low
        next_r.pin_seen = pin_active;
        done_ev  = 1'b0;
        // Link sequencer
        case (r.st)
            esil_pkg::ESIL_HOST_REQ: begin
                next_r.req = 1'b1;
                next_r.st  = esil_pkg::ESIL_HOST_WAIT;
            end
            esil_pkg::ESIL_HOST_WAIT: begin
                if (link.ack) begin
                    next_r.req   = 1'b0;
                    next_r.rdata = link.rdata;
                    next_r.st    = esil_pkg::ESIL_HOST_IDLE;
                    done_ev      = 1'b1;
                end
            end
            default: next_r.st = esil_pkg::ESIL_HOST_IDLE;
        endcase
        // Sticky events, set wins over clear
        next_r.pready  = access;
        next_r.pslverr = 1'b0;
        if (access && pwrite && paddr == `ESIL_APB_IRQ_STATUS)
            next_r.irq_status = r.irq_status & ~pwdata[1:0];
        if (access && pwrite && paddr == `ESIL_APB_IRQ_MASK)
            next_r.irq_mask = pwdata[1:0];
        if (access && pwrite && paddr == `ESIL_APB_CMD && r.st == esil_pkg::ESIL_HOST_IDLE) begin
            next_r.addr  = pwdata[7:0];
            next_r.write = pwdata[`ESIL_CMD_WRITE_BIT];
            if (pwdata[`ESIL_CMD_GO_BIT])
                next_r.st = esil_pkg::ESIL_HOST_REQ;
        end
        if (access && pwrite && paddr == `ESIL_APB_WDATA)
            next_r.wdata = pwdata[7:0];
        // Must-be-zero bit of the mode byte is cleared only when a command is accepted
        if (access && pwrite && paddr == `ESIL_APB_CMD && r.st == esil_pkg::ESIL_HOST_IDLE &&
            pwdata[7:0] == `ESIL_ADDR_MODE)
            next_r.wdata[`ESIL_BIT_MODE_MBZ] = 1'b0;        // R2
        if (done_ev)
            next_r.irq_status[0] = 1'b1;
        if (pin_active && !r.pin_seen)
            next_r.irq_status[1] = 1'b1;
        // Read mux
        if (access && !pwrite) begin
            case (paddr)
                `ESIL_APB_CMD:        next_r.prdata = {22'h0, (r.st != esil_pkg::ESIL_HOST_IDLE), r.write, r.addr};
                `ESIL_APB_WDATA:      next_r.prdata = {24'h0, r.wdata};
                `ESIL_APB_RDATA:      next_r.prdata = {24'h0, (r.addr == `ESIL_ADDR_PRODUCT_ID) ?
                                                       (r.rdata & `ESIL_ID_FIXED_MASK) : r.rdata}; // R4
                `ESIL_APB_STATUS:     next_r.prdata = {30'h0, pin_active, (r.st != esil_pkg::ESIL_HOST_IDLE)};
                `ESIL_APB_IRQ_STATUS: next_r.prdata = {30'h0, r.irq_status};
                `ESIL_APB_IRQ_MASK:   next_r.prdata = {30'h0, r.irq_mask};
                default: begin
                    next_r.prdata  = 32'h0;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.pin_sync <= 2'h3;                             // Pin idles high, no false edge
        end else begin
            r <= next_r;
        end
    end

    assign link.req   = r.req;
    assign link.write = r.write;
    assign link.addr  = r.addr;
    assign link.wdata = r.wdata;
    assign prdata     = r.prdata;
    assign pready     = r.pready;
    assign pslverr    = r.pslverr;
    assign irq        = r.irq;
endmodule : esil_host

// *** verification/esil_chk.sv ***
`timescale 1ns/1ps
`include "esil_defs.svh"
// ****************************************
// Link handshake and register checker
// ****************************************
module esil_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       req,
    input wire logic       write,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack
);
    logic [7:0] en_copy;
    logic [7:0] cal_copy [6];
    wire        rd_ack = ack && !write;
    wire        cal_hit = addr >= `ESIL_ADDR_Y_OFFSET_HIGH && addr <= `ESIL_ADDR_Z_GAIN_LOW;

    // Shadow copies of values written across the link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_copy  <= 8'h00;
            cal_copy <= '{default: 8'h00};
        end else if (ack && write) begin
            if (addr == `ESIL_ADDR_IRQ_ENABLE) en_copy <= wdata;
            if (cal_hit) cal_copy[3'(addr - 8'h24)] <= wdata;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Request is taken and answered within a few cycles
    sequence s_take; $rose(req); endsequence
    sequence s_answer; ##[1:4] ack; endsequence
    property p_ack_latency; s_take |-> s_answer; endproperty
    property p_ack_pulse; ack |=> !ack; endproperty
    property p_ack_cause; ack |-> req; endproperty
    property p_req_hold; req && !ack |=> req; endproperty
    property p_req_stable; req && !ack |=> $stable({write, addr, wdata}); endproperty
    property p_req_release; ack |-> ##[1:2] !req; endproperty
    property p_en_readback; rd_ack && addr == `ESIL_ADDR_IRQ_ENABLE |-> rdata == (en_copy & `ESIL_IRQ_EN_MASK);
    endproperty
    property p_cal_readback; rd_ack && cal_hit |-> rdata == cal_copy[3'(addr - 8'h24)]; endproperty
    property p_state_code; rd_ack && addr == `ESIL_ADDR_DEVICE_STATUS |-> rdata[6:5] == 2'h0 && rdata[3:1] == 3'h0;
    endproperty
    property p_event_resv; rd_ack && addr == `ESIL_ADDR_EVENT_STATUS |-> !rdata[6]; endproperty
    property p_mode_mbz; req && write && addr == `ESIL_ADDR_MODE |-> !wdata[`ESIL_BIT_MODE_MBZ]; endproperty

    a_ack_latency: assert property (p_ack_latency) else $error("link answer late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    a_req_stable: assert property (p_req_stable) else $error("request changed while pending");
    a_req_release: assert property (p_req_release) else $error("request not released");
    a_en_readback: assert property (p_en_readback) else $error("irq enable readback wrong");
    a_cal_readback: assert property (p_cal_readback) else $error("calibration readback wrong");
    a_state_code: assert property (p_state_code) else $error("state field reserved code");
    a_event_resv: assert property (p_event_resv) else $error("event status bit 6 set");
    a_mode_mbz: assert property (p_mode_mbz) else $error("mode must-be-zero bit sent set");
endmodule : esil_chk

// *** verification/tb.sv ***
`timescale 1ns/1ps
`include "esil_defs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
// ****************************************
// Bench for host controller and sensor logic
// ****************************************
module tb;
    localparam logic [7:0] ID_STRAP = 8'h5a; // Arbitrary strap value
    typedef struct {logic [31:0] v; logic [31:0] m;} esil_tb_exp_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_val;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_val;
    logic [5:0]  tap_event;
    logic        sample_event, active_state, otp_active, bus_stall, bus_reset, rst_seen;
    logic [7:0]  tap_control, mode;
    int          fail_count, checks_done;
    esil_tb_exp_s exp_q[$];
    esil_tb_exp_s e;
    esil_link_if link ();
    wire         pin = link.irq_pin_oe ? link.irq_pin_out : 1'b1;

    esil_device #(.WDT_CYCLES(20)) esil_device_i (.pclk(pclk), .presetn(presetn), .link(link),
        .tap_event(tap_event), .sample_event(sample_event), .active_state(active_state),
        .otp_active(otp_active), .bus_stall(bus_stall), .factory_id(ID_STRAP), .bus_reset(bus_reset),
        .tap_control(tap_control), .mode(mode));
    esil_host esil_host_i (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    esil_chk esil_chk_i (.pclk(pclk), .presetn(presetn), .req(link.req), .write(link.write),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));

    // Clock
    always #2.5 pclk = ~pclk;

    // Compare each finished read with the oldest expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e.m != 0) `CHK(prdata & e.m, e.v & e.m)
        end
        if (bus_reset === 1'b1) rst_seen <= 1'b1;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ev,
                       input logic [31:0] em);
        if (!w) exp_q.push_back('{ev, em});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_val  = prdata;
        err_val = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_idle();
        do apb(1'b0, `ESIL_APB_STATUS, 0, 0, 0); while (rd_val[0] !== 1'b0);
    endtask : wait_idle

    task automatic lwr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, `ESIL_APB_WDATA, {24'h0, d}, 0, 0);
        apb(1'b1, `ESIL_APB_CMD, {22'h0, 2'h3, a}, 0, 0);
        wait_idle();
    endtask : lwr

    task automatic lrd(input logic [7:0] a, input logic [7:0] ev, input logic [7:0] em);
        apb(1'b1, `ESIL_APB_CMD, {22'h0, 2'h2, a}, 0, 0);
        wait_idle();
        apb(1'b0, `ESIL_APB_RDATA, 0, {24'h0, ev}, {24'h0, em});
    endtask : lrd

    task automatic pulse(input logic [5:0] t, input logic s);
        tap_event    <= t;
        sample_event <= s;
        @(posedge pclk);
        tap_event    <= 6'h0;
        sample_event <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse

    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        logic [7:0] v, a, m;
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; rst_seen = 0;
        tap_event = 0; sample_event = 0; active_state = 0; otp_active = 1; bus_stall = 0;
        void'($urandom(95));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        lrd(`ESIL_ADDR_IRQ_ENABLE, 8'h00, 8'hff);
        lrd(`ESIL_ADDR_DEVICE_STATUS, 8'h80, 8'hff);
        otp_active   <= 1'b0;
        active_state <= 1'b1;
        repeat (4) @(posedge pclk);
        lrd(`ESIL_ADDR_DEVICE_STATUS, 8'h01, 8'hff);
        for (int i = 0; i < 7; i++) begin
            v = 8'($urandom);
            a = (i == 6) ? `ESIL_ADDR_IRQ_ENABLE : 8'h24 + 8'(i);
            m = (i == 6) ? `ESIL_IRQ_EN_MASK : 8'hff;
            lwr(a, v);
            lrd(a, v & m, 8'hff);
        end
        lwr(`ESIL_ADDR_IRQ_ENABLE, 8'h00);
        lwr(`ESIL_ADDR_PRODUCT_ID, ~ID_STRAP);
        lrd(`ESIL_ADDR_PRODUCT_ID, ID_STRAP & `ESIL_ID_FIXED_MASK, 8'hff);
        apb(1'b0, 12'h020, 0, 0, 0);
        `CHK(err_val, 1'b1)
        lwr(`ESIL_ADDR_TAP_CONTROL, 8'h00);
        pulse(6'h3f, 1'b0);
        lrd(`ESIL_ADDR_EVENT_STATUS, 8'h00, 8'hff);
        lwr(`ESIL_ADDR_TAP_CONTROL, 8'hbf);
        `CHK(tap_control, 8'hbf)
        for (int i = 0; i < 6; i++) begin
            pulse(6'(1 << i), 1'b0);
            lrd(`ESIL_ADDR_EVENT_STATUS, 8'(1 << i), 8'hff);
            lrd(`ESIL_ADDR_EVENT_STATUS, 8'h00, 8'hff);
        end
        pulse(6'h01, 1'b1);
        `CHK(pin, 1'b1)
        lrd(`ESIL_ADDR_EVENT_STATUS, 8'h81, 8'hff);
        apb(1'b1, `ESIL_APB_IRQ_MASK, 32'h2, 0, 0);
        lwr(`ESIL_ADDR_IRQ_ENABLE, 8'h01);
        pulse(6'h01, 1'b0);
        `CHK(pin, 1'b0)
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, `ESIL_APB_IRQ_STATUS, 32'h3, 0, 0);
        `CHK(irq, 1'b0)
        lrd(`ESIL_ADDR_EVENT_STATUS, 8'h01, 8'hff);
        `CHK(pin, 1'b1)
        lwr(`ESIL_ADDR_IRQ_ENABLE, 8'h80);
        pulse(6'h01, 1'b0);
        `CHK(pin, 1'b1)
        pulse(6'h00, 1'b1);
        `CHK(pin, 1'b0)
        lrd(`ESIL_ADDR_EVENT_STATUS, 8'h81, 8'hff);
        lwr(`ESIL_ADDR_MODE, 8'h84);
        `CHK(mode, 8'h80)
        `CHK(pin, 1'b0)
        pulse(6'h00, 1'b1);
        `CHK(pin, 1'b1)
        lrd(`ESIL_ADDR_EVENT_STATUS, 8'h80, 8'hff);
        lwr(`ESIL_ADDR_MODE, 8'h10);
        bus_stall <= 1'b1;
        repeat (10) @(posedge pclk);
        bus_stall <= 1'b0;
        lrd(`ESIL_ADDR_DEVICE_STATUS, 8'h00, 8'h10);
        bus_stall <= 1'b1;
        repeat (30) @(posedge pclk);
        bus_stall <= 1'b0;
        lrd(`ESIL_ADDR_DEVICE_STATUS, 8'h10, 8'h10);
        `CHK(rst_seen, 1'b1)
        lrd(`ESIL_ADDR_DEVICE_STATUS, 8'h00, 8'h10);
        fork
            lrd(`ESIL_ADDR_IRQ_ENABLE, 8'h80, 8'hff);
            begin
                wait (link.req === 1'b1);
                pulse(6'h04, 1'b0);
            end
        join
        lrd(`ESIL_ADDR_EVENT_STATUS, 8'h04, 8'hff);
        complete_run();
    end
endmodule : tb
